// ### dv/sdc_host.sv
/*
 Host model for the delay register: issues one decoded command per call.
 Assumes the caller checks each answer before making the next call.
*/
`timescale 1ns/1ps
`default_nettype none
module sdc_host (
   // Clock.
   input  wire logic              clock,
   // Command out.
   output var  sdc_pkg::sdc_req_s req
);
   import sdc_pkg::*;
   initial req = '0;
   task automatic xfer(input logic wr, input logic [7:0] pg, input logic [7:0] wd);
      @(posedge clock);
      req <= '{valid: 1'b1, write: wr, code: SDC_CMD_CODE, page: pg, wdata: wd};
      @(posedge clock);
      // Released data shows the inverse so stale values are never reused.
      req <= '{valid: 1'b0, write: wr, code: SDC_CMD_CODE, page: ~pg, wdata: ~wd};
   endtask : xfer
endmodule : sdc_host
`default_nettype wire

// ### dv/tb.sv
/*
 Testbench for the delay register: host calls with expected answers.
 Assumes the answer comes one cycle after the request is taken.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sdc_pkg::*;
   logic                  clock = 1'b0;
   logic                  rst = 1'b1;
   sdc_req_s              req;
   sdc_rsp_s              rsp;
   logic [1:0]            follower = 2'b00;
   logic [63:0]           rise = {32'h3, 32'hA};
   logic                  load_user = 1'b0;
   logic [15:0]           user_value = 16'h0000;
   logic                  fault;
   logic                  alert_n;
   logic [15:0]           cfg;
   sdc_delay_s [1:0]      dly;
   int                    fails = 0;
   int                    n_tests = 0;
   initial forever #12.5 clock = ~clock;
   sdc_host host (.clock(clock), .req(req));
   sdc_top #(.NCH(2)) DUT (.clock(clock), .rst(rst), .req(req), .rsp(rsp),
      .follower(follower), .soft_start_rise_time(rise), .load_user(load_user),
      .user_value(user_value), .invalid_command_fault(fault), .smbalert_n(alert_n),
      .cfg_out(cfg), .delays(dly));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic acc(input logic wr, input logic [7:0] pg, input logic [7:0] wd,
                      input logic ak, input logic [7:0] rd);
      host.xfer(wr, pg, wd);
      #1;
      chk("rsp.valid", 1, rsp.valid);
      chk("rsp.ack", ak, rsp.ack);
      chk("rsp.rdata", rd, rsp.rdata);
   endtask : acc
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      chk("cfg reset", 0, cfg);
      chk("alert reset", 1, alert_n);
      acc(1, SDC_PAGE_CH1, 8'hB5, 1, 8'h00);
      repeat (2) @(posedge clock);
      #1;
      chk("ch1 on", 5 * 10, dly[0].on_cyc);
      chk("ch1 off", 2 * 10, dly[0].off_cyc);
      acc(0, SDC_PAGE_CH1, 8'h00, 1, 8'hA4);
      acc(0, SDC_PAGE_CH2, 8'h00, 1, 8'h00);
      acc(1, SDC_PAGE_BOTH, 8'h62, 1, 8'h00);
      repeat (2) @(posedge clock);
      #1;
      chk("both cfg", 16'h6262, cfg);
      chk("ch2 on", 3 * 3, dly[1].on_cyc);
      chk("ch2 off", 1 * 3, dly[1].off_cyc);
      @(posedge clock);
      load_user <= 1'b1;
      user_value <= 16'h2EC1;
      @(posedge clock);
      load_user <= 1'b0;
      #1;
      chk("user cfg", 16'h2EC0, cfg);
      acc(0, SDC_PAGE_BOTH, 8'h00, 1, 8'hC0);
      @(posedge clock);
      follower <= 2'b10;
      repeat (2) @(posedge clock);
      #1;
      chk("fol on", SDC_MIN_ON_CYC, dly[1].on_cyc);
      chk("fol off", 0, dly[1].off_cyc);
      chk("fault idle", 0, fault);
      acc(1, SDC_PAGE_CH2, 8'hFF, 0, 8'h00);
      chk("fol cfg", 16'h2EC0, cfg);
      chk("fault", 1, fault);
      chk("alert", 0, alert_n);
      acc(0, SDC_PAGE_CH2, 8'h00, 0, 8'h00);
      acc(1, SDC_PAGE_BOTH, 8'h22, 0, 8'h00);
      acc(1, 8'h02, 8'h22, 0, 8'h00);
      #1;
      chk("kept cfg", 16'h2EC0, cfg);
      @(posedge clock);
      follower <= 2'b11;
      repeat (2) @(posedge clock);
      #1;
      chk("fol1 on", SDC_MIN_ON_CYC, dly[0].on_cyc);
      chk("fol1 off", 0, dly[0].off_cyc);
      acc(0, SDC_PAGE_CH1, 8'h00, 0, 8'h00);
      acc(1, SDC_PAGE_CH1, 8'h44, 0, 8'h00);
      chk("fol1 cfg", 16'h2EC0, cfg);
      end_sim();
   end
endmodule : tb
`default_nettype wire

// ### src/sdc_mul.sv
/*
 Registered delay calculator: multiplies a rise time in clock cycles by a
 3-bit ratio code, or forces fixed values for a follower channel.
 Assumes the rise time input is stable for a cycle before use.
*/
`timescale 1ns/1ps
`default_nettype none
module sdc_mul (
   // Clock and reset.
   input  wire logic               clock,
   input  wire logic               rst,
   // Operands.
   input  wire logic [31:0]        rise_cyc,
   input  wire logic [7:0]         cfg,
   input  wire logic               follower,
   // Result.
   output var  sdc_pkg::sdc_delay_s delay
);
   import sdc_pkg::*;
   typedef struct packed {
      sdc_delay_s delay;
   } sdc_mul_state_s;
   sdc_mul_state_s st_q;
   sdc_mul_state_s st_d;

   always_comb begin
      st_d = st_q;
      // R04 follower fixed delays.
      if (follower) begin
         st_d.delay.on_cyc  = 32'(SDC_MIN_ON_CYC);
         st_d.delay.off_cyc = 32'h0;
      end else begin
         // R01 R08 R09 ratio of rise time.
         st_d.delay.on_cyc  = 32'(rise_cyc * 32'(cfg[SDC_ON_MSB:SDC_ON_LSB]));
         st_d.delay.off_cyc = 32'(rise_cyc * 32'(cfg[SDC_OFF_MSB:SDC_OFF_LSB]));
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign delay = st_q.delay;
endmodule : sdc_mul
`default_nettype wire

// ### src/sdc_pkg.sv
/*
 Package for the sequencing delay configuration block: command code, pages,
 field positions, reset values, timing constants and the structs that carry
 command and delay information.
 Assumes a 40 MHz clock and a PMBus front end that decodes transactions.
*/
package sdc_pkg;
   localparam logic [7:0] SDC_CMD_CODE        = 8'hD8;
   localparam logic [7:0] SDC_PAGE_CH1        = 8'h00;
   localparam logic [7:0] SDC_PAGE_CH2        = 8'h01;
   localparam logic [7:0] SDC_PAGE_BOTH       = 8'h0B;
   localparam int         SDC_ON_MSB          = 7;
   localparam int         SDC_ON_LSB          = 5;
   localparam int         SDC_OFF_MSB         = 3;
   localparam int         SDC_OFF_LSB         = 1;
   localparam logic [7:0] SDC_FIELD_MASK      = 8'hEE;
   localparam logic [7:0] SDC_FACTORY_DEFAULT = 8'h00;
   localparam int         SDC_CLK_HZ          = 40000000;
   localparam int         SDC_MIN_ON_US       = 50;
   localparam int         SDC_MIN_ON_CYC      = (SDC_MIN_ON_US * (SDC_CLK_HZ / 1000000));
   localparam int         SDC_CH              = 2;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] code;
      logic [7:0] page;
      logic [7:0] wdata;
   } sdc_req_s;

   typedef struct packed {
      logic       valid;
      logic       ack;
      logic [7:0] rdata;
   } sdc_rsp_s;

   typedef struct packed {
      logic [31:0] on_cyc;
      logic [31:0] off_cyc;
   } sdc_delay_s;
endpackage : sdc_pkg

// ### src/sdc_top.sv
/*
 Sequencing delay configuration register for a two-channel buck controller.
 Assumes a PMBus front end presents one decoded transaction per valid pulse,
 and that the saved user value is stable while load_user is high.
*/
// Overview of operation
// R01 - Delays are ratios of rise time
// R02 - Page 0, 1 or 11 selects channels
// R03 - Follower channel blocks access, discards writes
// R04 - Follower forces 50 us on, zero off
// R05 - Follower access NACKed, fault, alert raised
// R06 - Factory default 000X 000X, no delays
// R07 - Power-up value loads from saved settings
// R08 - Bits 7:5 turn-on delay code
// R09 - Bits 3:1 turn-off delay code
// R10 - Bits 4 and 0 ignored, read zero
// R11 - Both-page write updates all non-followers; the code refuses the whole write if either channel is a follower
`timescale 1ns/1ps
`default_nettype none
module sdc_top #(
   parameter int NCH = 2
) (
   // Clock and reset.
   input  wire logic                clock,
   input  wire logic                rst,
   // Decoded command from the bus front end.
   input  wire sdc_pkg::sdc_req_s   req,
   output var  sdc_pkg::sdc_rsp_s   rsp,
   // Channel configuration.
   input  wire logic [NCH-1:0]      follower,
   input  wire logic [NCH*32-1:0]   soft_start_rise_time,
   // Saved user settings.
   input  wire logic                load_user,
   input  wire logic [NCH*8-1:0]    user_value,
   // Status.
   output var  logic                invalid_command_fault,
   output var  logic                smbalert_n,
   output var  logic [NCH*8-1:0]    cfg_out,
   output var  sdc_pkg::sdc_delay_s [NCH-1:0] delays
);
   import sdc_pkg::*;

   typedef struct packed {
      logic [NCH-1:0][7:0] cfg;
      sdc_rsp_s            rsp;
      logic                fault;
      logic                alert_n;
   } sdc_state_s;

   sdc_state_s st_q;
   sdc_state_s st_d;
   logic [NCH-1:0] sel;
   logic           page_ok;
   logic           hit;
   logic           blocked;

   always_comb begin
      // R02 page decode.
      sel     = '0;
      page_ok = 1'b1;
      unique case (req.page)
         SDC_PAGE_CH1:  sel[0] = 1'b1;
         SDC_PAGE_CH2:  sel[1] = 1'b1;
         SDC_PAGE_BOTH: sel    = '1;
         default:       page_ok = 1'b0;
      endcase
      hit = req.valid && (req.code == SDC_CMD_CODE);
      // R03 R05 follower blocks access.
      blocked = |(sel & follower) || !page_ok;
   end

   always_comb begin
      st_d = st_q;
      st_d.rsp.valid = 1'b0;
      // R07 load saved user settings.
      if (load_user) begin
         for (int i = 0; i < NCH; i++) begin
            st_d.cfg[i] = user_value[i*8 +: 8] & SDC_FIELD_MASK;
         end
      end else if (hit) begin
         st_d.rsp.valid = 1'b1;
         st_d.rsp.ack   = !blocked;
         st_d.rsp.rdata = 8'h00;
         if (blocked) begin
            // R05 fault and alert.
            st_d.fault   = 1'b1;
            st_d.alert_n = 1'b0;
         end else if (req.write) begin
            // R10 R11 masked write to each selected channel.
            for (int i = 0; i < NCH; i++) begin
               if (sel[i]) begin
                  st_d.cfg[i] = req.wdata & SDC_FIELD_MASK;
               end
            end
         end else begin
            st_d.rsp.rdata = sel[0] ? st_q.cfg[0] : st_q.cfg[1];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         // R06 factory default.
         for (int i = 0; i < NCH; i++) begin
            st_q.cfg[i] <= SDC_FACTORY_DEFAULT;
         end
         st_q.rsp     <= '0;
         st_q.fault   <= 1'b0;
         st_q.alert_n <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         // R08 R09 per-channel delay calculators.
         sdc_mul u_mul (
            .clock    (clock),
            .rst      (rst),
            .rise_cyc (soft_start_rise_time[g*32 +: 32]),
            .cfg      (st_q.cfg[g]),
            .follower (follower[g]),
            .delay    (delays[g])
         );
         assign cfg_out[g*8 +: 8] = st_q.cfg[g];
      end
   endgenerate

   assign rsp                   = st_q.rsp;
   assign invalid_command_fault = st_q.fault;
   assign smbalert_n            = st_q.alert_n;

   chk_follower_nack : assert property (@(posedge clock) disable iff (rst) // R05
      hit && blocked && !load_user |=> rsp.valid && !rsp.ack && !smbalert_n)
      else $error("follower access not refused");

   chk_follower_keep : assert property (@(posedge clock) disable iff (rst) // R03
      hit && (sel[0] & follower[0]) && !load_user |=> $stable(st_q.cfg[0]))
      else $error("follower config changed");

   chk_fol2_keep : assert property (@(posedge clock) disable iff (rst) // R03
      hit && (sel[1] & follower[1]) && !load_user |=> $stable(st_q.cfg[1]))
      else $error("second follower config changed");

   chk_unused_zero : assert property (@(posedge clock) disable iff (rst) // R10
      (cfg_out & {NCH{~SDC_FIELD_MASK}}) == '0)
      else $error("unused bits not zero");

   chk_ch1_write : assert property (@(posedge clock) disable iff (rst) // R10
      hit && req.write && !blocked && req.page == SDC_PAGE_CH1 && !load_user
      |=> rsp.ack && cfg_out[7:0] == ($past(req.wdata) & SDC_FIELD_MASK))
      else $error("channel 1 write not masked");

   chk_both_write : assert property (@(posedge clock) disable iff (rst) // R11
      hit && req.write && !blocked && req.page == SDC_PAGE_BOTH && !load_user
      |=> st_q.cfg[0] == st_q.cfg[1])
      else $error("both-page write mismatch");

   chk_both_read : assert property (@(posedge clock) disable iff (rst) // R02
      hit && !req.write && !blocked && req.page == SDC_PAGE_BOTH && !load_user
      |=> rsp.ack && rsp.rdata == $past(st_q.cfg[0]))
      else $error("both-page read not channel 1");

   chk_ch1_untouched : assert property (@(posedge clock) disable iff (rst) // R02
      hit && req.page == SDC_PAGE_CH2 && !load_user |=> $stable(st_q.cfg[0]))
      else $error("channel 2 access changed channel 1");

   chk_bad_page : assert property (@(posedge clock) disable iff (rst) // R02
      hit && !page_ok && !load_user |=> !rsp.ack && $stable(cfg_out))
      else $error("invalid page not refused");

   chk_follower_delay : assert property (@(posedge clock) disable iff (rst) // R04
      follower[0] |=> delays[0].on_cyc == 32'(SDC_MIN_ON_CYC) && delays[0].off_cyc == 0)
      else $error("follower delay not forced");

   chk_fol2_delay : assert property (@(posedge clock) disable iff (rst) // R04
      follower[1] |=> delays[1].on_cyc == 32'(SDC_MIN_ON_CYC) && delays[1].off_cyc == 0)
      else $error("second follower delay not forced");

   chk_on_ratio : assert property (@(posedge clock) disable iff (rst) // R08
      !follower[0] ##1 !follower[0] |-> delays[0].on_cyc ==
      32'($past(soft_start_rise_time[31:0]) * 32'($past(st_q.cfg[0][7:5]))))
      else $error("turn-on delay ratio wrong");

   chk_off_ratio : assert property (@(posedge clock) disable iff (rst) // R09 R01
      !follower[1] ##1 !follower[1] |-> delays[1].off_cyc ==
      32'($past(soft_start_rise_time[63:32]) * 32'($past(st_q.cfg[1][3:1]))))
      else $error("turn-off delay ratio wrong");

   chk_user_load : assert property (@(posedge clock) disable iff (rst) // R07
      load_user |=> cfg_out == (($past(user_value)) & {NCH{SDC_FIELD_MASK}}))
      else $error("user value not loaded");

   chk_page_sel : assert property (@(posedge clock) disable iff (rst) // R02
      hit && !req.write && !blocked && req.page == SDC_PAGE_CH2 && !load_user
      |=> rsp.ack && rsp.rdata == $past(st_q.cfg[1]))
      else $error("page 1 read wrong");

   chk_reset_val : assert property (@(posedge clock) disable iff (rst) // R06
      $past(rst) |-> cfg_out == '0 && smbalert_n)
      else $error("reset value wrong");

   chk_rsp_answer : assert property (@(posedge clock) disable iff (rst) // R02
      hit && !load_user |=> rsp.valid)
      else $error("command not answered");

   chk_rsp_quiet : assert property (@(posedge clock) disable iff (rst) // R05
      !hit || load_user |=> !rsp.valid)
      else $error("answer without command");

   chk_nack_rdata : assert property (@(posedge clock) disable iff (rst) // R05
      rsp.valid && !rsp.ack |-> rsp.rdata == 8'h00)
      else $error("refused access returned data");

   chk_fault_sticky : assert property (@(posedge clock) disable iff (rst) // R05
      invalid_command_fault |=> invalid_command_fault)
      else $error("fault cleared without reset");

   chk_alert_pair : assert property (@(posedge clock) disable iff (rst) // R05
      invalid_command_fault == !smbalert_n)
      else $error("fault and alert disagree");
endmodule : sdc_top
`default_nettype wire
